// ### common/csf_pkg.sv
// What this block does
// - bank bits pick direct bank: 00 bank0, 01 bank1, 10 bank2, 11 bank3
// - every bank spans 128 bytes of data address space
// - expiry flag goes 1 at power-up, watchdog clear and sleep
// - expiry flag goes 0 on watchdog timeout
// - zero flag follows whether the result of add, subtract, and, or, xor is zero
// - nibble flag is carry out of bit 3 for add and subtract
// - carry flag is carry out of bit 7 for add and subtract
// - subtract adds two's complement; carries then mean not-borrow
// - rotates load carry with the bit shifted out
// - power-on: low bank bit 0, expiry and power-down 1, read-only
// - status answers at data addresses 03h and 83h
// - reset cause flags tell power-on and brown-out apart; pin and watchdog resets leave them alone
// - brown-out flag 0 at power-on, software sets, brown-out clears
// - brown-out flag is don't-care when detection is disabled
// - flag-updating instruction into status blocks data write to three flags
// - software writes never change expiry or power-down flags
package csf_pkg;
    localparam int DIR_W = 7;
    localparam int ADDR_W = 9;
    localparam int BANK_BYTES = 128;
    localparam logic [8:0] STATUS_ADDR_LO = 9'h003;
    localparam logic [8:0] STATUS_ADDR_HI = 9'h083;
    localparam logic [8:0] CAUSE_ADDR = 9'h08E;
    localparam int BIT_INDIRECT = 7;
    localparam int BIT_BANK_HIGH = 6;
    localparam int BIT_BANK_LOW = 5;
    localparam int BIT_EXPIRY = 4;
    localparam int BIT_POWER_DOWN = 3;
    localparam int BIT_Z = 2;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_C = 0;
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_BOR_BIT = 0;
    localparam logic [2:0] BANK_RST = 3'h0;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic EXPIRY_RST = 1'b1;
    localparam logic POWER_DOWN_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b0;
    localparam logic BOR_FLAG_RST = 1'b0;
    localparam logic [7:0] READ_MISS = 8'h00;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_ROTL,
        OP_ROTR
    } csf_alu_op_t;
endpackage

// ### core/csf_flag_calc.sv
`timescale 1ns/1ps
`default_nettype none
module csf_flag_calc (
    // operation and operands
    input wire csf_pkg::csf_alu_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_carry,
    // result and flags
    output logic [7:0] o_result,
    output logic o_zero,
    output logic o_nibble,
    output logic o_carry,
    output logic o_upd_zero,
    output logic o_upd_carry
);
    logic [7:0] addend;
    logic add_cin;
    logic [8:0] sum;
    logic [4:0] nib;

    // subtract is a + ~b + 1, so both carries come out as not-borrow
    always_comb begin
        addend = (i_op == csf_pkg::OP_SUB) ? ~i_b : i_b;
        add_cin = (i_op == csf_pkg::OP_SUB);
        sum = {1'b0, i_a} + {1'b0, addend} + {8'h00, add_cin};
        nib = {1'b0, i_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};
    end

    // result and flag selection per operation
    always_comb begin
        o_result = i_a;
        o_nibble = 1'b0;
        o_carry = i_carry;
        o_upd_zero = 1'b0;
        o_upd_carry = 1'b0;
        case (i_op)
            csf_pkg::OP_ADD, csf_pkg::OP_SUB: begin
                o_result = sum[7:0];
                o_nibble = nib[4];
                o_carry = sum[8];
                o_upd_zero = 1'b1;
                o_upd_carry = 1'b1;
            end
            csf_pkg::OP_AND: begin
                o_result = i_a & i_b;
                o_upd_zero = 1'b1;
            end
            csf_pkg::OP_OR: begin
                o_result = i_a | i_b;
                o_upd_zero = 1'b1;
            end
            csf_pkg::OP_XOR: begin
                o_result = i_a ^ i_b;
                o_upd_zero = 1'b1;
            end
            csf_pkg::OP_ROTL: begin
                o_result = {i_a[6:0], i_carry};
                o_carry = i_a[7];
                o_upd_carry = 1'b1;
            end
            csf_pkg::OP_ROTR: begin
                o_result = {i_carry, i_a[7:1]};
                o_carry = i_a[0];
                o_upd_carry = 1'b1;
            end
            default: begin
                o_result = i_a;
            end
        endcase
        o_zero = (o_result == 8'h00);
    end
endmodule
`default_nettype wire

// ### core/csf_reset_cause.sv
`timescale 1ns/1ps
`default_nettype none
module csf_reset_cause (
    // clock and power-on reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // software write
    input wire logic i_wr,
    input wire logic [7:0] i_wr_data,
    // brown-out events
    input wire logic i_bor_reset,
    input wire logic i_bor_enable,
    // register contents
    output logic [7:0] o_cause
);
    logic por_flag;
    logic bor_flag;

    // power-on clears this; software sets it to spot the next power-on
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_flag <= csf_pkg::POR_FLAG_RST;
        end else if (i_wr) begin
            por_flag <= i_wr_data[csf_pkg::CAUSE_POR_BIT];
        end
    end

    // brown-out clear beats a write in the same cycle, so the event is kept
    // when detection is off the flag is simply held and carries no meaning
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bor_flag <= csf_pkg::BOR_FLAG_RST;
        end else if (i_bor_reset && i_bor_enable) begin
            bor_flag <= 1'b0;
        end else if (i_wr) begin
            bor_flag <= i_wr_data[csf_pkg::CAUSE_BOR_BIT];
        end
    end

    // unused bits read as zero
    always_comb begin
        o_cause = 8'h00;
        o_cause[csf_pkg::CAUSE_POR_BIT] = por_flag;
        o_cause[csf_pkg::CAUSE_BOR_BIT] = bor_flag;
    end
endmodule
`default_nettype wire

// ### core/csf_status_core.sv
`timescale 1ns/1ps
`default_nettype none
module csf_status_core (
    // clock and power-on reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // other resets, one-cycle pulses from the reset controller
    input wire logic i_ext_reset,
    input wire logic i_watchdog_reset,
    input wire logic i_bor_reset,
    input wire logic i_bor_enable,
    // core events
    input wire logic i_watchdog_clear_instr,
    input wire logic i_sleep_instr,
    input wire logic i_watchdog_timeout,
    // internal data bus
    input wire logic [6:0] i_dir_addr,
    input wire logic i_rd_en,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_data,
    // arithmetic unit request
    input wire csf_pkg::csf_alu_op_t i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    // bus answers and state
    output logic [8:0] o_data_addr,
    output logic [7:0] o_rd_data,
    output logic o_rd_hit,
    output logic [7:0] o_alu_result,
    output logic [7:0] o_status,
    output logic [7:0] o_reset_cause
);
    logic indirect_bank_bit;
    logic bank_sel_high;
    logic bank_sel_low;
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic zero_flag;
    logic nibble_overflow_flag;
    logic carry_flag;
    logic status_hit;
    logic cause_hit;
    logic status_wr;
    logic [7:0] calc_result;
    logic calc_zero;
    logic calc_nibble;
    logic calc_carry;
    logic upd_zero;
    logic upd_carry;
    logic flag_instr;

    // direct address: bank bits on top of the 7-bit offset, 128 bytes per bank
    assign o_data_addr = {bank_sel_high, bank_sel_low, i_dir_addr};

    // status is mirrored in banks 0 and 1 so it is reachable from either without switching
    assign status_hit = (o_data_addr == csf_pkg::STATUS_ADDR_LO) ||
                        (o_data_addr == csf_pkg::STATUS_ADDR_HI);
    assign cause_hit = (o_data_addr == csf_pkg::CAUSE_ADDR);
    assign status_wr = i_wr_en && status_hit;
    assign flag_instr = upd_zero || upd_carry;

    // arithmetic flag computation
    csf_flag_calc u_calc (
        .i_op(i_alu_op),
        .i_a(i_alu_a),
        .i_b(i_alu_b),
        .i_carry(carry_flag),
        .o_result(calc_result),
        .o_zero(calc_zero),
        .o_nibble(calc_nibble),
        .o_carry(calc_carry),
        .o_upd_zero(upd_zero),
        .o_upd_carry(upd_carry)
    );

    // reset cause register
    csf_reset_cause u_cause (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_wr(i_wr_en && cause_hit),
        .i_wr_data(i_wr_data),
        .i_bor_reset(i_bor_reset),
        .i_bor_enable(i_bor_enable),
        .o_cause(o_reset_cause)
    );

    // bank bits are plain storage; the reserved ones are kept clear by software
    // other resets leave them alone
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {indirect_bank_bit, bank_sel_high, bank_sel_low} <= csf_pkg::BANK_RST;
        end else if (status_wr) begin
            indirect_bank_bit <= i_wr_data[csf_pkg::BIT_INDIRECT];
            bank_sel_high <= i_wr_data[csf_pkg::BIT_BANK_HIGH];
            bank_sel_low <= i_wr_data[csf_pkg::BIT_BANK_LOW];
        end
    end

    // expiry flag: a timeout wins over a clear so it is never lost
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            watchdog_expiry_flag <= csf_pkg::EXPIRY_RST;
        end else if (i_watchdog_timeout || i_watchdog_reset) begin
            watchdog_expiry_flag <= 1'b0;
        end else if (i_bor_reset || i_watchdog_clear_instr || i_sleep_instr) begin
            watchdog_expiry_flag <= 1'b1;
        end
    end

    // power-down flag; no bus write reaches either of these two flags
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            power_down_flag <= csf_pkg::POWER_DOWN_RST;
        end else if (i_bor_reset) begin
            power_down_flag <= 1'b1;
        end else if (i_sleep_instr) begin
            power_down_flag <= 1'b0;
        end else if (i_watchdog_clear_instr) begin
            power_down_flag <= 1'b1;
        end
    end

    // arithmetic flags: when the instruction updates flags, the data write
    // to all three is dropped; result may then differ from what was written
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {zero_flag, nibble_overflow_flag, carry_flag} <= csf_pkg::FLAGS_RST;
        end else if (flag_instr) begin
            if (upd_zero) begin
                zero_flag <= calc_zero;
            end
            if (upd_carry) begin
                carry_flag <= calc_carry;
            end
            if (i_alu_op == csf_pkg::OP_ADD || i_alu_op == csf_pkg::OP_SUB) begin
                nibble_overflow_flag <= calc_nibble;
            end
        end else if (status_wr) begin
            zero_flag <= i_wr_data[csf_pkg::BIT_Z];
            nibble_overflow_flag <= i_wr_data[csf_pkg::BIT_NIBBLE];
            carry_flag <= i_wr_data[csf_pkg::BIT_C];
        end
    end

    // registered result so zero flag and result are seen together
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alu_result <= 8'h00;
        end else if (i_alu_op != csf_pkg::OP_NONE) begin
            o_alu_result <= calc_result;
        end
    end

    // read port answers one cycle after the request; misses read zero
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= csf_pkg::READ_MISS;
            o_rd_hit <= 1'b0;
        end else begin
            o_rd_hit <= i_rd_en && (status_hit || cause_hit);
            if (i_rd_en && status_hit) begin
                o_rd_data <= o_status;
            end else if (i_rd_en && cause_hit) begin
                o_rd_data <= o_reset_cause;
            end else begin
                o_rd_data <= csf_pkg::READ_MISS;
            end
        end
    end

    // live status word
    assign o_status = {indirect_bank_bit, bank_sel_high, bank_sel_low, watchdog_expiry_flag,
                       power_down_flag, zero_flag, nibble_overflow_flag, carry_flag};

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_bank_write;
        status_wr && !flag_instr;
    endsequence

    sequence s_quiet;
        !i_watchdog_timeout && !i_watchdog_reset && !i_bor_reset;
    endsequence

    property p_bank_addr;
        s_bank_write |=> o_data_addr[8:7] == $past(i_wr_data[6:5]);
    endproperty
    a_bank_addr: assert property (p_bank_addr)
        else $error("bank bits do not steer the address");

    property p_timeout;
        i_watchdog_timeout |=> !o_status[4];
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("expiry flag not cleared on timeout");

    property p_clear_instr;
        (i_watchdog_clear_instr && !i_sleep_instr) and s_quiet |=> o_status[4] && o_status[3];
    endproperty
    a_clear_instr: assert property (p_clear_instr)
        else $error("watchdog clear did not set both flags");

    property p_sleep;
        i_sleep_instr and s_quiet |=> o_status[4] && !o_status[3];
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep flags wrong");

    property p_zero;
        upd_zero |=> o_status[2] == (o_alu_result == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag does not match result");

    property p_nibble;
        i_alu_op == csf_pkg::OP_ADD |=>
            o_status[1] == $past(({1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}) > 5'd15);
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("nibble flag wrong on add");

    property p_sub_carry;
        i_alu_op == csf_pkg::OP_SUB |=> o_status[0] == $past(i_alu_a >= i_alu_b);
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("carry is not not-borrow on subtract");

    property p_rotl;
        i_alu_op == csf_pkg::OP_ROTL |=> o_status[0] == $past(i_alu_a[7]);
    endproperty
    a_rotl: assert property (p_rotl)
        else $error("rotate left did not load carry");

    property p_write_block;
        status_wr && i_alu_op == csf_pkg::OP_ROTL |=> o_status[2:1] == $past(o_status[2:1]);
    endproperty
    a_write_block: assert property (p_write_block)
        else $error("flag write not blocked");

    property p_ro_flags;
        (status_wr && !i_sleep_instr && !i_watchdog_clear_instr) and s_quiet |=>
            o_status[4:3] == $past(o_status[4:3]);
    endproperty
    a_ro_flags: assert property (p_ro_flags)
        else $error("software changed expiry or power-down flag");

    property p_mirror;
        i_rd_en && status_hit |=> o_rd_hit && o_rd_data == $past(o_status);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("status read wrong at mirror address");

    property p_ext_keep;
        i_ext_reset && !i_wr_en && i_alu_op == csf_pkg::OP_NONE |=>
            {o_status[6:5], o_status[2:0]} == $past({o_status[6:5], o_status[2:0]});
    endproperty
    a_ext_keep: assert property (p_ext_keep)
        else $error("pin reset disturbed flags or bank");

    property p_bor_clear;
        i_bor_reset && i_bor_enable |=> !o_reset_cause[0];
    endproperty
    a_bor_clear: assert property (p_bor_clear)
        else $error("brown-out flag not cleared");
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clock;
    logic i_rst_n;
    logic i_ext_reset, i_watchdog_reset, i_bor_reset, i_bor_enable;
    logic i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout;
    logic [6:0] i_dir_addr;
    logic i_rd_en, i_wr_en;
    logic [7:0] i_wr_data, i_alu_a, i_alu_b;
    csf_pkg::csf_alu_op_t i_alu_op;
    logic [8:0] o_data_addr;
    logic [7:0] o_rd_data, o_alu_result, o_status, o_reset_cause;
    logic o_rd_hit;
    int n_errors = 0;
    int checks = 0;

    csf_status_core dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ext_reset(i_ext_reset), .i_watchdog_reset(i_watchdog_reset),
        .i_bor_reset(i_bor_reset), .i_bor_enable(i_bor_enable), .i_watchdog_clear_instr(i_watchdog_clear_instr),
        .i_sleep_instr(i_sleep_instr), .i_watchdog_timeout(i_watchdog_timeout), .i_dir_addr(i_dir_addr),
        .i_rd_en(i_rd_en), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_alu_op(i_alu_op),
        .i_alu_a(i_alu_a), .i_alu_b(i_alu_b), .o_data_addr(o_data_addr), .o_rd_data(o_rd_data),
        .o_rd_hit(o_rd_hit), .o_alu_result(o_alu_result), .o_status(o_status), .o_reset_cause(o_reset_cause)
    );

    // 100 ns core clock
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // inputs always move 10 ns after the rising edge so no race with the design
    task automatic tick();
        @(posedge i_clock);
        #10;
    endtask

    task automatic do_reset();
        i_rst_n = 1'b0;
        repeat (5) tick();
        i_rst_n = 1'b1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_dir_addr = a;
        i_wr_data = d;
        i_wr_en = 1'b1;
        tick();
        i_wr_en = 1'b0;
    endtask

    // read data stands only for the cycle after the request, so it is judged right here
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic hit);
        i_dir_addr = a;
        i_rd_en = 1'b1;
        tick();
        i_rd_en = 1'b0;
        chk_val({1'b0, o_rd_data}, {1'b0, exp});
        chk_bit(o_rd_hit, hit);
    endtask

    // order: pin reset, watchdog reset, brown-out reset, watchdog clear, sleep, timeout
    task automatic ev(input logic [5:0] v);
        {i_ext_reset, i_watchdog_reset, i_bor_reset,
         i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = v;
        tick();
        {i_ext_reset, i_watchdog_reset, i_bor_reset,
         i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = 6'h00;
    endtask

    task automatic t_reset();
        chk_val({1'b0, o_status}, 9'h018);
        chk_val({1'b0, o_reset_cause}, 9'h000);
        chk_bit(o_rd_hit, 1'b0);
        chk_val({1'b0, o_rd_data}, 9'h000);
        chk_val({1'b0, o_alu_result}, 9'h000);
        $display("test reset values done");
    endtask

    // every bank code, even the reserved upper ones, with a fresh reset to get back to bank 0
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, {1'b0, b[1:0], 5'h00});
            i_dir_addr = 7'h03;
            #1;
            chk_val(o_data_addr, {b[1:0], 7'h03});
            rd(7'h03, (b < 2) ? {1'b0, b[1:0], 5'h18} : 8'h00, b < 2);
            do_reset();
        end
        $display("test bank select done");
    endtask

    task automatic t_protect();
        wr(7'h03, 8'h07);
        chk_val({1'b0, o_status}, 9'h01F);
        wr(7'h03, 8'h00);
        chk_val({1'b0, o_status}, 9'h018);
        i_alu_op = csf_pkg::OP_ADD;
        i_alu_a = 8'h01;
        i_alu_b = 8'h01;
        wr(7'h03, 8'h07);
        i_alu_op = csf_pkg::OP_NONE;
        chk_val({1'b0, o_status}, 9'h018);
        chk_val({1'b0, o_alu_result}, 9'h002);
        // rotate with a status write in the same cycle: only carry may move
        i_alu_op = csf_pkg::OP_ROTL;
        i_alu_a = 8'h80;
        wr(7'h03, 8'h06);
        i_alu_op = csf_pkg::OP_NONE;
        chk_val({1'b0, o_status}, 9'h019);
        chk_val({1'b0, o_alu_result}, 9'h000);
        $display("test write protection done");
    endtask

    task automatic t_alu();
        csf_pkg::csf_alu_op_t ops [9];
        logic [7:0] av [9];
        logic [7:0] bv [9];
        logic [7:0] rv [9];
        logic [2:0] fv [9];
        ops = '{csf_pkg::OP_ADD, csf_pkg::OP_ADD, csf_pkg::OP_SUB, csf_pkg::OP_SUB, csf_pkg::OP_ROTL,
                csf_pkg::OP_ROTR, csf_pkg::OP_AND, csf_pkg::OP_XOR, csf_pkg::OP_OR};
        av = '{8'h0F, 8'hFF, 8'h05, 8'h00, 8'h81, 8'h02, 8'hF0, 8'h5A, 8'h00};
        bv = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00, 8'h0F, 8'h5A, 8'h01};
        rv = '{8'h10, 8'h00, 8'h00, 8'hFF, 8'h02, 8'h81, 8'h00, 8'h00, 8'h01};
        fv = '{3'h2, 3'h7, 3'h7, 3'h0, 3'h1, 3'h0, 3'h4, 3'h4, 3'h0};
        // rotates reuse the carry left by the entry before, so the table order matters
        for (int k = 0; k < 9; k++) begin
            i_alu_op = ops[k];
            i_alu_a = av[k];
            i_alu_b = bv[k];
            tick();
            i_alu_op = csf_pkg::OP_NONE;
            chk_val({1'b0, o_alu_result}, {1'b0, rv[k]});
            chk_val({1'b0, o_status}, {6'h03, fv[k]});
        end
        $display("test flag arithmetic done");
    endtask

    task automatic t_events();
        logic [5:0] evs [7];
        logic [1:0] tp [7];
        evs = '{6'h02, 6'h01, 6'h04, 6'h10, 6'h08, 6'h03, 6'h20};
        tp = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h3, 2'h0, 2'h0};
        wr(7'h03, 8'h24);
        for (int k = 0; k < 7; k++) begin
            ev(evs[k]);
            chk_val({1'b0, o_status}, {4'h1, tp[k], 3'h4});
        end
        $display("test status events done");
    endtask

    task automatic t_cause();
        wr(7'h03, 8'h20);
        wr(7'h0E, 8'h03);
        chk_val({1'b0, o_reset_cause}, 9'h003);
        rd(7'h0E, 8'h03, 1'b1);
        i_bor_enable = 1'b1;
        ev(6'h08);
        chk_val({1'b0, o_reset_cause}, 9'h002);
        ev(6'h20);
        chk_val({1'b0, o_reset_cause}, 9'h002);
        rd(7'h0F, 8'h00, 1'b0);
        rd(7'h03, 8'h38, 1'b1);
        $display("test reset cause done");
    endtask

    // cut a hang short well beyond the some 60 cycles the tests need
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        i_rst_n = 1'b0;
        {i_ext_reset, i_watchdog_reset, i_bor_reset,
         i_watchdog_clear_instr, i_sleep_instr, i_watchdog_timeout} = 6'h00;
        i_bor_enable = 1'b0;
        i_dir_addr = 7'h00;
        i_rd_en = 1'b0;
        i_wr_en = 1'b0;
        i_wr_data = 8'h00;
        i_alu_op = csf_pkg::OP_NONE;
        i_alu_a = 8'h00;
        i_alu_b = 8'h00;
        do_reset();
        t_reset();
        t_banks();
        t_protect();
        t_alu();
        t_events();
        t_cause();
        tally_and_finish();
    end
endmodule
`default_nettype wire
